//--- tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import viu_pkg::*;
  // ****************
  // stimulus and model
  // ****************
  logic clk_in = 1'b0, rst_in = 1'b1, ea = 1'b1, eb = 1'b1, ca = 1'b1, cb = 1'b1;
  logic software_break = 1'b0, stop_instruction = 1'b0, wti = 1'b0, clr = 1'b0, tk_push = 1'b0, rdy, flag, push, setd, pd;
  logic [7:0] wp = 8'hFF, pol, rq1, rq2, en1, en2;
  viu_int_src_t src = '0;
  viu_wr_t pw = '0, r1w = '0, r2w = '0, e1w = '0, e2w = '0;
  viu_take_t take;
  viu_take_t tk = '0;
  int error_cnt = 0, n_checks = 0, cyc = 0, seed = 17, pend = 0, r, n_tk = 0;

  always #12.5 clk_in = ~clk_in;

  viu_core_model u_viu_core_model (.clk_in(clk_in), .rst_in(rst_in), .set_disable_in(setd),
    .clr_flag_in(clr), .ready_en_in(1'b1), .core_ready_out(rdy), .disable_flag_out(flag));

  viu_top u_viu_top (.clk_in(clk_in), .rst_in(rst_in), .ext_irq_a_in(ea), .ext_irq_b_in(eb),
    .counter_pin_a_in(ca), .counter_pin_b_in(cb), .wake_port_in(wp), .int_src_in(src),
    .software_break_in(software_break), .stop_instruction_in(stop_instruction), .wait_instruction_in(wti),
    .core_ready_in(rdy), .disable_flag_in(flag), .pol_wr_in(pw), .req1_wr_in(r1w),
    .req2_wr_in(r2w), .en1_wr_in(e1w), .en2_wr_in(e2w), .take_out(take), .push_regs_out(push),
    .set_disable_out(setd), .power_down_out(pd), .pol_out(pol), .req1_out(rq1),
    .req2_out(rq2), .en1_out(en1), .en2_out(en2));

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : give_verdict

  always @(posedge clk_in)
  begin
    cyc <= cyc + 1;
    if (cyc == 4000)
    begin
      error_cnt++;
      give_verdict();
    end
  end

  // a take stands one cycle only, so catch it mid-cycle
  always @(negedge clk_in)
  begin
    if (take.valid === 1'b1)
    begin
      tk      <= take;
      tk_push <= push & setd;
      n_tk    <= n_tk + 1;
    end
  end

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic wt(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask : wt

  // writes: 0 pol, 1 req1, 2 en1, 3 req2, 4 en2
  task automatic wr(input int k, input logic [7:0] d);
    @(posedge clk_in);
    case (k)
      0: pw <= '{1'b1, d};
      1: r1w <= '{1'b1, d};
      2: e1w <= '{1'b1, d};
      3: r2w <= '{1'b1, d};
      default: e2w <= '{1'b1, d};
    endcase
    @(posedge clk_in);
    {pw.we, r1w.we, e1w.we, r2w.we, e2w.we} <= 5'h00;
    if (k == 1)
      pend = pend & {24'hFFFFFF, d};
    #1;
  endtask : wr

  task automatic ev(input logic [5:0] s, input logic b, input logic st);
    @(posedge clk_in);
    src <= viu_int_src_t'(s);
    software_break <= b;
    stop_instruction <= st;
    @(posedge clk_in);
    src <= '0;
    software_break <= 1'b0;
    stop_instruction <= 1'b0;
    for (int k = 0; k < 6; k++)
      if (s[k])
        pend[8-k] = 1'b1;
  endtask : ev

  // break is unmaskable, so the flag is left set for it
  task automatic got(input int p);
    int i;
    int base;
    i = 0;
    base = n_tk;
    if (p != 11)
    begin
      @(posedge clk_in) clr <= 1'b1;
      @(posedge clk_in) clr <= 1'b0;
    end
    if (p == 0)
      for (int k = 8; k >= 0; k--)
        if (pend[k])
          p = k + 2;
    if (p inside {[2:10]})
      pend[p-2] = 1'b0;
    while (n_tk == base && i < 40)
    begin
      @(negedge clk_in);
      i++;
    end
    chk("taken", 16'(n_tk - base), 16'h0001);
    chk("prio", 16'(tk.prio), 16'(p));
    chk("vector", tk.vector, 16'(32'hFFFE - 2 * (p - 1)));
    chk("push", 16'(tk_push), 16'h0001);
    chk("req1", 16'(rq1), 16'(pend[7:0]));
    chk("req2", 16'(rq2), 16'(pend[8]));
  endtask : got

  initial
  begin
    repeat (8) @(posedge clk_in);
    rst_in <= 1'b0;
    got(1);
    r = $random(seed);
    wr(2, r[7:0]);
    chk("en1", 16'(en1), 16'(r[7:0]));
    wr(2, 8'hFF);
    wr(4, 8'hFF);
    chk("en2", 16'(en2), 16'h0001);
    $display("test boot and enables done");
    ev(6'b101000, 1'b0, 1'b0);
    wt(10);
    chk("held", 16'(rq1), 16'(pend[7:0]));
    wr(1, 8'hDF);
    chk("req clear", 16'(rq1), 16'(pend[7:0]));
    wr(1, 8'hFF);
    chk("req noset", 16'(rq1), 16'(pend[7:0]));
    got(0);
    ev(6'b000101, 1'b0, 1'b0);
    got(0);
    got(0);
    ev(6'h00, 1'b1, 1'b0);
    got(11);
    $display("test internal sources done");
    for (int k = 0; k < 2; k++)
    begin
      // park the pin at the active end while the other sense is selected
      wr(0, 8'(1 - k));
      @(posedge clk_in) ea <= k[0];
      wt(8);
      wr(0, 8'(k));
      chk("pol", 16'(pol), 16'(k));
      @(posedge clk_in) ea <= ~k[0];
      wt(8);
      chk("ext quiet", 16'(rq1[0]), 16'h0000);
      @(posedge clk_in) ea <= k[0];
      wt(8);
      pend[0] = 1'b1;
      chk("ext edge", 16'(rq1[0]), 16'h0001);
      got(0);
    end
    wr(0, 8'h18);
    @(posedge clk_in) cb <= 1'b0;
    ca <= 1'b0;
    wt(8);
    chk("cnt quiet", 16'(rq1[2]), 16'h0000);
    @(posedge clk_in) cb <= 1'b1;
    wt(8);
    pend[2] = 1'b1;
    chk("cnt edge", 16'(rq1[2]), 16'h0001);
    got(0);
    $display("test pins done");
    wr(0, 8'h20);
    @(posedge clk_in) wp <= 8'hFE;
    eb <= 1'b0;
    wt(8);
    chk("key idle", 16'(rq1[1]), 16'h0000);
    @(posedge clk_in) wp <= 8'hFF;
    ev(6'h00, 1'b0, 1'b1);
    wt(4);
    chk("power down", 16'(pd), 16'h0001);
    @(posedge clk_in) wp <= 8'hF7;
    wt(8);
    pend[1] = 1'b1;
    chk("key wake", 16'(rq1[1]), 16'h0001);
    @(posedge clk_in) wp <= 8'hFF;
    got(0);
    wr(0, 8'h00);
    @(posedge clk_in) eb <= 1'b1;
    wt(8);
    @(posedge clk_in) wti <= 1'b1;
    @(posedge clk_in) wti <= 1'b0;
    wt(4);
    chk("wait down", 16'(pd), 16'h0001);
    @(posedge clk_in) eb <= 1'b0;
    wt(8);
    pend[1] = 1'b1;
    chk("pin wake", 16'(rq1[1]), 16'h0001);
    chk("woken", 16'(pd), 16'h0000);
    got(0);
    $display("test key wake done");
    give_verdict();
  end
endmodule : tb
`default_nettype wire

//--- viu_core_model.sv
`timescale 1ns/1ps
`default_nettype none
// ****************
// core side: owns the disable flag, drives core ready
// ****************
module viu_core_model
(
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic set_disable_in,
  input  wire logic clr_flag_in,
  input  wire logic ready_en_in,
  output logic      core_ready_out,
  output logic      disable_flag_out
);
  always_ff @(posedge clk_in)
  begin
    core_ready_out <= ready_en_in & ~rst_in;
    if (rst_in || clr_flag_in)
      disable_flag_out <= 1'b0;
    else if (set_disable_in)
      disable_flag_out <= 1'b1;
  end
endmodule : viu_core_model
`default_nettype wire

//--- viu_edge_det.sv
`timescale 1ns/1ps
`default_nettype none
module viu_edge_det
  import viu_pkg::*;
(
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic pin_in,
  input  wire logic rising_in,
  output logic      event_out
);

  logic s1_q, s1_d;
  logic s2_q, s2_d;
  logic s3_q, s3_d;

  // s1 only feeds s2; edges are judged on s2 against s3
  always_comb
  begin
    s1_d = pin_in;
    s2_d = s1_q;
    s3_d = s2_q;
    event_out = rising_in ? (s2_q & ~s3_q) : (~s2_q & s3_q);
  end

  // ****************************************
  // pins idle high so reset to one
  // ****************************************
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
    end
    else
    begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      s3_q <= s3_d;
    end
  end

endmodule : viu_edge_det
`default_nettype wire

//--- viu_pkg.sv
package viu_pkg;

  // ****************************************
  // source slots
  // ****************************************
  localparam int NUM_MASKABLE = 9;
  localparam int NUM_CAND     = 10;
  localparam int SRC_EXT_A    = 0;
  localparam int SRC_EXT_B    = 1;
  localparam int SRC_COUNTER  = 2;
  localparam int SRC_TIMER1   = 3;
  localparam int SRC_TIMER2   = 4;
  localparam int SRC_TIMER3   = 5;
  localparam int SRC_TIMER4   = 6;
  localparam int SRC_SERIAL   = 7;
  localparam int SRC_ADC      = 8;
  localparam int SRC_BREAK    = 9;

  // ****************************************
  // edge polarity register fields
  // ****************************************
  localparam int POL_EXT_A    = 0;
  localparam int POL_EXT_B    = 1;
  localparam int POL_CNT_A    = 2;
  localparam int POL_CNT_B    = 3;
  localparam int POL_CNT_SEL  = 4;
  localparam int POL_KEY_WAKE = 5;

  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] POL_RESET = 8'h00;
  localparam logic [7:0] REQ_RESET = 8'h00;
  localparam logic [7:0] EN_RESET  = 8'h00;
  localparam logic [7:0] WAKE_IDLE = 8'hFF;

  // ****************************************
  // vector table and priorities
  // ****************************************
  localparam logic [15:0] VEC_RESET  = 16'hFFFE;
  localparam logic [3:0]  PRIO_RESET = 4'h1;
  localparam logic [3:0]  PRIO_FIRST = 4'h2;

  typedef struct packed {
    logic        valid;
    logic [3:0]  prio;
    logic [15:0] vector;
  } viu_take_t;

  typedef struct packed {
    logic timer1;
    logic timer2;
    logic timer3;
    logic timer4;
    logic serial;
    logic adc_done;
  } viu_int_src_t;

  typedef struct packed {
    logic       we;
    logic [7:0] data;
  } viu_wr_t;

endpackage : viu_pkg

//--- viu_prio.sv
`timescale 1ns/1ps
`default_nettype none
module viu_prio
  import viu_pkg::*;
(
  input  wire logic [NUM_CAND-1:0] cand_in,
  output logic                     found_out,
  output logic [3:0]               index_out
);

  // lowest index wins: scan from the bottom of the order upward
  always_comb
  begin
    found_out = 1'b0;
    index_out = 4'h0;
    for (int i = NUM_CAND - 1; i >= 0; i--)
    begin
      if (cand_in[i])
      begin
        found_out = 1'b1;
        index_out = 4'(i);
      end
    end
  end

endmodule : viu_prio
`default_nettype wire

//--- viu_properties.sv
`timescale 1ns/1ps
`default_nettype none
module viu_properties
  import viu_pkg::*;
(
  input  wire logic              clk_in,
  input  wire logic              rst_in,
  input  wire logic              core_ready_in,
  input  wire logic              disable_flag_in,
  input  wire viu_pkg::viu_wr_t   en1_wr_in,
  input  wire viu_pkg::viu_take_t take_out,
  input  wire logic              push_regs_out,
  input  wire logic              set_disable_out,
  input  wire logic [7:0]        req1_out,
  input  wire logic [7:0]        req2_out,
  input  wire logic [7:0]        en1_out
);
  // ****************
  // take and register checks
  // ****************
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);

  AST_PUSH: assert property (push_regs_out == take_out.valid && set_disable_out == take_out.valid)
    else $error("push or disable pulse differs from take");
  AST_READY: assert property (take_out.valid |-> $past(core_ready_in))
    else $error("take without core ready");
  AST_SPACING: assert property (take_out.valid |=> !take_out.valid)
    else $error("takes back to back");
  AST_VEC_MAP: assert property (take_out.valid
    |-> take_out.vector == 16'hFFFE - 16'({take_out.prio - 4'h1, 1'b0}))
    else $error("vector does not match priority");
  AST_PRIO_RANGE: assert property (take_out.valid |-> take_out.prio inside {[1:11]})
    else $error("priority out of range");
  AST_MASKED: assert property (take_out.valid && take_out.prio inside {[2:10]} |-> !$past(disable_flag_in))
    else $error("maskable taken while disabled");
  AST_EN_NEEDED: assert property (take_out.valid && take_out.prio inside {[2:9]}
    |-> (($past(en1_out) >> (take_out.prio - 4'h2)) & 8'h01) == 8'h01)
    else $error("taken with enable bit clear");
  AST_REQ_CLR: assert property (take_out.valid && take_out.prio inside {[2:9]}
    |-> ((req1_out >> (take_out.prio - 4'h2)) & 8'h01) == 8'h00)
    else $error("request bit not cleared on take");
  AST_REQ2_RSV: assert property (req2_out[7:1] == 7'h00)
    else $error("unused request bits set");
  AST_EN_WR: assert property (en1_wr_in.we |=> en1_out == $past(en1_wr_in.data))
    else $error("enable write lost");
endmodule : viu_properties

bind viu_top viu_properties u_viu_properties (
  .clk_in(clk_in), .rst_in(rst_in), .core_ready_in(core_ready_in),
  .disable_flag_in(disable_flag_in), .en1_wr_in(en1_wr_in), .take_out(take_out),
  .push_regs_out(push_regs_out), .set_disable_out(set_disable_out),
  .req1_out(req1_out), .req2_out(req2_out), .en1_out(en1_out));
`default_nettype wire

//--- viu_top.sv
// Operation
// - ten sources: three pin, six internal, one software break
// - accepting pushes registers, sets disable flag, branches to the source vector
// - the accepted source's request bit clears in hardware
// - reset and software break are never masked
// - disable flag set blocks every maskable source
// - each source but break has request and enable bits, two registers each
// - polarity bit 0 means falling edge, 1 means rising edge
// - power-down with bit 5 set: low on any wake port pin raises request
// - power-down with bit 5 clear: second pin drives that slot
// - running with bit 5 set: that slot raises no request at all
// - counter interrupt is edge programmable; bit 4 picks counter pin
// - maskable taken only with enable 1, request 1, disable flag 0
// - software may clear request bits only; enable bits set and clear
// - reset is highest priority, vector at the top of memory
// - fixed order reset, pins, counter, timers, serial, converter, break
// - first pin is priority two, vector just below reset
// - second pin or key wake is priority three, third vector pair
// - converter done is priority ten, vector above the break vector
// - bits 2 and 3 choose each counter pin plain or inverted
`timescale 1ns/1ps
`default_nettype none
module viu_top
  import viu_pkg::*;
(
  input  wire logic                  clk_in,
  input  wire logic                  rst_in,
  input  wire logic                  ext_irq_a_in,
  input  wire logic                  ext_irq_b_in,
  input  wire logic                  counter_pin_a_in,
  input  wire logic                  counter_pin_b_in,
  input  wire logic [7:0]            wake_port_in,
  input  wire viu_pkg::viu_int_src_t int_src_in,
  input  wire logic                  software_break_in,
  input  wire logic                  stop_instruction_in,
  input  wire logic                  wait_instruction_in,
  input  wire logic                  core_ready_in,
  input  wire logic                  disable_flag_in,
  input  wire viu_pkg::viu_wr_t      pol_wr_in,
  input  wire viu_pkg::viu_wr_t      req1_wr_in,
  input  wire viu_pkg::viu_wr_t      req2_wr_in,
  input  wire viu_pkg::viu_wr_t      en1_wr_in,
  input  wire viu_pkg::viu_wr_t      en2_wr_in,
  output viu_pkg::viu_take_t         take_out,
  output logic                       push_regs_out,
  output logic                       set_disable_out,
  output logic                       power_down_out,
  output logic [7:0]                 pol_out,
  output logic [7:0]                 req1_out,
  output logic [7:0]                 req2_out,
  output logic [7:0]                 en1_out,
  output logic [7:0]                 en2_out
);

  import viu_pkg::*;

  // ****************************************
  // declarations
  // ****************************************
  typedef enum logic [2:0] {
    ST_BOOT = 3'b001,
    ST_RUN  = 3'b010,
    ST_HOLD = 3'b100
  } viu_state_t;

  viu_state_t               state_q, state_d;
  logic [7:0]               wake_s1_q, wake_s1_d;
  logic [7:0]               wake_s2_q, wake_s2_d;
  logic [3:0]               pin_raw;
  logic [3:0]               pin_rise;
  logic [3:0]               pin_event;
  logic [NUM_MASKABLE-1:0]  src_event;
  logic [NUM_MASKABLE-1:0]  req_q, req_d;
  logic [NUM_MASKABLE-1:0]  en_q, en_d;
  logic [NUM_MASKABLE-1:0]  sw_keep;
  logic [NUM_MASKABLE-1:0]  take_clr;
  logic [7:0]               pol_q, pol_d;
  logic                     brk_q, brk_d;
  logic                     pd_q, pd_d;
  logic                     key_low;
  logic                     counter_event;
  logic [NUM_CAND-1:0]      cand;
  logic                     found;
  logic [3:0]               found_idx;
  logic [3:0]               prio_m1;
  logic                     take_now;
  viu_take_t                take_q, take_d;

  // ****************************************
  // wake port synchroniser
  // ****************************************
  always_comb
  begin
    wake_s1_d = wake_port_in;
    wake_s2_d = wake_s1_q;
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      wake_s1_q <= WAKE_IDLE;
      wake_s2_q <= WAKE_IDLE;
    end
    else
    begin
      wake_s1_q <= wake_s1_d;
      wake_s2_q <= wake_s2_d;
    end
  end

  // ****************************************
  // pin edge detection
  // ****************************************
  // counter pins use bits 2 and 3 as plain or inverted, so a 1 there
  // picks the rising edge of the pin itself, the same sense as the
  // external pins' polarity bits
  always_comb
  begin
    pin_raw  = {counter_pin_b_in, counter_pin_a_in, ext_irq_b_in, ext_irq_a_in};
    pin_rise = {pol_q[POL_CNT_B], pol_q[POL_CNT_A], pol_q[POL_EXT_B], pol_q[POL_EXT_A]};
  end

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++)
    begin : g_pin
      viu_edge_det u_edge (
        .clk_in    (clk_in),
        .rst_in    (rst_in),
        .pin_in    (pin_raw[gi]),
        .rising_in (pin_rise[gi]),
        .event_out (pin_event[gi])
      );
    end
  endgenerate

  // ****************************************
  // source events
  // ****************************************
  always_comb
  begin
    key_low       = ~(&wake_s2_q);
    counter_event = pol_q[POL_CNT_SEL] ? pin_event[3] : pin_event[2];
    src_event     = '0;
    src_event[SRC_EXT_A] = pin_event[0];
    if (pol_q[POL_KEY_WAKE])
    begin
      // key wake is a level: held keys keep requesting while powered down
      src_event[SRC_EXT_B] = pd_q & key_low;
    end
    else
    begin
      src_event[SRC_EXT_B] = pin_event[1];
    end
    src_event[SRC_COUNTER] = counter_event;
    src_event[SRC_TIMER1]  = int_src_in.timer1;
    src_event[SRC_TIMER2]  = int_src_in.timer2;
    src_event[SRC_TIMER3]  = int_src_in.timer3;
    src_event[SRC_TIMER4]  = int_src_in.timer4;
    src_event[SRC_SERIAL]  = int_src_in.serial;
    src_event[SRC_ADC]     = int_src_in.adc_done;
  end

  // ****************************************
  // power-down state
  // ****************************************
  // any enabled request ends power-down, regardless of the disable flag,
  // so the core wakes even if it then cannot take the interrupt
  always_comb
  begin
    pd_d = pd_q;
    if (|(req_q & en_q))
    begin
      pd_d = 1'b0;
    end
    else if (stop_instruction_in | wait_instruction_in)
    begin
      pd_d = 1'b1;
    end
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      pd_q <= 1'b0;
    end
    else
    begin
      pd_q <= pd_d;
    end
  end

  // ****************************************
  // polarity, enable and request registers
  // ****************************************
  always_comb
  begin
    pol_d = pol_q;
    en_d  = en_q;
    if (pol_wr_in.we)
    begin
      pol_d = pol_wr_in.data;
    end
    if (en1_wr_in.we)
    begin
      en_d[7:0] = en1_wr_in.data;
    end
    if (en2_wr_in.we)
    begin
      en_d[NUM_MASKABLE-1:8] = en2_wr_in.data[NUM_MASKABLE-9:0];
    end
  end

  always_comb
  begin
    sw_keep = '1;
    if (req1_wr_in.we)
    begin
      sw_keep[7:0] = req1_wr_in.data;
    end
    if (req2_wr_in.we)
    begin
      sw_keep[NUM_MASKABLE-1:8] = req2_wr_in.data[NUM_MASKABLE-9:0];
    end
    take_clr = '0;
    if (take_now && found_idx != 4'(SRC_BREAK))
    begin
      take_clr[found_idx] = 1'b1;
    end
    // a new event in the cycle of a clear keeps its bit set
    req_d = (req_q & sw_keep & ~take_clr) | src_event;
    brk_d = software_break_in | (brk_q & ~(take_now && found_idx == 4'(SRC_BREAK)));
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      pol_q <= POL_RESET;
      en_q  <= {EN_RESET[0], EN_RESET};
      req_q <= {REQ_RESET[0], REQ_RESET};
      brk_q <= 1'b0;
    end
    else
    begin
      pol_q <= pol_d;
      en_q  <= en_d;
      req_q <= req_d;
      brk_q <= brk_d;
    end
  end

  // ****************************************
  // acceptance and priority
  // ****************************************
  always_comb
  begin
    cand = '0;
    cand[NUM_MASKABLE-1:0] = (req_q & en_q) & {NUM_MASKABLE{~disable_flag_in}};
    cand[SRC_BREAK] = brk_q;
  end

  viu_prio u_prio (
    .cand_in   (cand),
    .found_out (found),
    .index_out (found_idx)
  );

  always_comb
  begin
    state_d  = state_q;
    take_now = 1'b0;
    prio_m1  = 4'(found_idx + 4'h1);
    take_d   = '0;
    case (state_q)
      ST_BOOT:
      begin
        if (core_ready_in)
        begin
          take_d.valid  = 1'b1;
          take_d.prio   = PRIO_RESET;
          take_d.vector = VEC_RESET;
          state_d       = ST_HOLD;
        end
      end
      ST_RUN:
      begin
        if (core_ready_in && found)
        begin
          take_now      = 1'b1;
          take_d.valid  = 1'b1;
          take_d.prio   = 4'(found_idx + PRIO_FIRST);
          take_d.vector = VEC_RESET - {11'h000, prio_m1, 1'b0};
          state_d       = ST_HOLD;
        end
      end
      ST_HOLD:
      begin
        // one idle cycle lets the core's disable flag catch up
        state_d = ST_RUN;
      end
      default:
      begin
        state_d = ST_BOOT;
      end
    endcase
  end

  always_ff @(posedge clk_in)
  begin
    if (rst_in)
    begin
      state_q <= ST_BOOT;
      take_q  <= '0;
    end
    else
    begin
      state_q <= state_d;
      take_q  <= take_d;
    end
  end

  // ****************************************
  // outputs
  // ****************************************
  always_comb
  begin
    take_out        = take_q;
    push_regs_out   = take_q.valid;
    set_disable_out = take_q.valid;
    power_down_out  = pd_q;
    pol_out         = pol_q;
    req1_out        = req_q[7:0];
    req2_out        = {7'h00, req_q[NUM_MASKABLE-1:8]};
    en1_out         = en_q[7:0];
    en2_out         = {7'h00, en_q[NUM_MASKABLE-1:8]};
  end

endmodule : viu_top
`default_nettype wire
